// file: design/sleep_gate_pkg.sv
package sleep_gate_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned UNIT_N = 9;
    // system control base, kept for software maps only
    localparam logic [31:0] SYS_CTRL_BASE = 32'h400F_E000;
    localparam logic [ADDR_W-1:0] SLEEP_GATE_OFS = 12'h118;
    localparam logic [ADDR_W-1:0] FAULT_STAT_OFS = 12'h120;
    localparam logic [ADDR_W-1:0] FAULT_MASK_OFS = 12'h124;
    localparam logic [ADDR_W-1:0] UNIT_STATE_OFS = 12'h128;
    localparam logic [31:0] SLEEP_GATE_RST = 32'h0000_0000;
    localparam logic [31:0] SLEEP_GATE_WMASK = 32'h5000_007F;
    localparam logic [UNIT_N-1:0] FAULT_STAT_RST = 9'h000;
    localparam logic [UNIT_N-1:0] FAULT_MASK_RST = 9'h000;
    localparam int unsigned PHY_BIT = 30;
    localparam int unsigned MAC_BIT = 28;
    localparam int unsigned PORT_LSB = 0;
    localparam int unsigned PORT_N = 7;
    // unit vector order: {phy, mac, port g .. port a}
    localparam int unsigned UNIT_PHY = 8;
    localparam int unsigned UNIT_MAC = 7;
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP_AUTO,
        MODE_SLEEP_HOLD
    } gate_mode_t;
endpackage

// file: design/sleep_clock_gate.sv
// Chosen here: register access over Avalon-MM.
module sleep_clock_gate
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // avalon-mm slave
    input wire logic [sleep_gate_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [sleep_gate_pkg::DATA_W-1:0] i_avs_writedata,
    output logic [sleep_gate_pkg::DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // power state and run-mode settings
    input wire logic i_sleep_mode,
    input wire logic i_auto_clock_gate_select,
    input wire logic [sleep_gate_pkg::DATA_W-1:0] i_run_clock_gate,
    // unit side: {phy, mac, port g .. port a}
    input wire logic [sleep_gate_pkg::UNIT_N-1:0] i_unit_access,
    output logic [sleep_gate_pkg::UNIT_N-1:0] o_unit_clock_en,
    output logic [sleep_gate_pkg::UNIT_N-1:0] o_bus_fault,
    // interrupt
    output logic o_irq
);
    import sleep_gate_pkg::*;

    // pick the unit gate bits out of a register-layout word
    function automatic logic [UNIT_N-1:0] units_of(input logic [31:0] word);
        units_of = {word[PHY_BIT], word[MAC_BIT], word[PORT_LSB +: PORT_N]};
    endfunction

    // expand byte enables into a bit mask
    function automatic logic [31:0] lanes_of(input logic [3:0] be);
        lanes_of = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    logic [31:0] sleep_gate_r;
    logic [31:0] sleep_gate_nxt;
    logic [UNIT_N-1:0] fault_stat_r;
    logic [UNIT_N-1:0] fault_stat_nxt;
    logic [UNIT_N-1:0] fault_mask_r;
    logic [UNIT_N-1:0] fault_mask_nxt;
    logic [UNIT_N-1:0] clock_en_r;
    logic [UNIT_N-1:0] clock_en_nxt;
    logic [UNIT_N-1:0] fault_r;
    logic [UNIT_N-1:0] fault_nxt;
    logic [31:0] rdata_r;
    logic ack_r;
    gate_mode_t mode;

    // bus decode
    wire logic req = i_avs_read | i_avs_write;
    wire logic take = req & ~ack_r;
    wire logic wr_take = i_avs_write & ack_r;
    wire logic hit_gate = i_avs_address == SLEEP_GATE_OFS;
    wire logic hit_stat = i_avs_address == FAULT_STAT_OFS;
    wire logic hit_mask = i_avs_address == FAULT_MASK_OFS;
    wire logic hit_unit = i_avs_address == UNIT_STATE_OFS;
    wire logic [31:0] lanes = lanes_of(i_avs_byteenable);
    wire logic [31:0] wbits = i_avs_writedata & lanes;

    assign sleep_gate_nxt = (wr_take & hit_gate)
        ? ((sleep_gate_r & ~lanes) | wbits) & SLEEP_GATE_WMASK
        : sleep_gate_r;

    assign fault_mask_nxt = (wr_take & hit_mask)
        ? (fault_mask_r & ~lanes[UNIT_N-1:0]) | wbits[UNIT_N-1:0]
        : fault_mask_r;

    // set wins over a write-one clear in the same cycle
    assign fault_stat_nxt = (wr_take & hit_stat)
        ? (fault_stat_r & ~wbits[UNIT_N-1:0]) | fault_nxt
        : fault_stat_r | fault_nxt;

    always_comb
    begin
        mode = MODE_RUN;
        if (i_sleep_mode)
        begin
            mode = i_auto_clock_gate_select ? MODE_SLEEP_AUTO : MODE_SLEEP_HOLD;
        end
    end

    // in sleep mode, auto select picks the sleep register
    // otherwise run gating stays in force
    always_comb
    begin
        case (mode)
            MODE_RUN: clock_en_nxt = units_of(i_run_clock_gate);
            MODE_SLEEP_AUTO: clock_en_nxt = units_of(sleep_gate_r);
            MODE_SLEEP_HOLD: clock_en_nxt = units_of(i_run_clock_gate);
            default: clock_en_nxt = '0;
        endcase
    end

    // fault on access to a gated unit
    assign fault_nxt = i_unit_access & ~clock_en_r;

    // read mux; unmapped offsets read as zero
    wire logic [31:0] rd_mux =
        hit_gate ? sleep_gate_r :
        hit_stat ? {{(32-UNIT_N){1'b0}}, fault_stat_r} :
        hit_mask ? {{(32-UNIT_N){1'b0}}, fault_mask_r} :
        hit_unit ? {{(32-UNIT_N){1'b0}}, clock_en_r} :
        32'h0000_0000;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            sleep_gate_r <= SLEEP_GATE_RST;
            fault_stat_r <= FAULT_STAT_RST;
            fault_mask_r <= FAULT_MASK_RST;
        end
        else
        begin
            sleep_gate_r <= sleep_gate_nxt;
            fault_stat_r <= fault_stat_nxt;
            fault_mask_r <= fault_mask_nxt;
        end
    end

    // registered clock enables
    // one cycle of latency keeps enable changes glitch free
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            clock_en_r <= '0;
            fault_r <= '0;
        end
        else
        begin
            clock_en_r <= clock_en_nxt;
            fault_r <= fault_nxt;
        end
    end

    // one wait state per access; read data is captured at the edge that ends the wait state
    // so it stands at the edge that ends the access, and writes land on that same edge
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= take;
            if (i_avs_read & take)
            begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign o_avs_waitrequest = req & ~ack_r;
    assign o_avs_readdata = rdata_r;
    assign o_unit_clock_en = clock_en_r;
    assign o_bus_fault = fault_r;
    assign o_irq = |(fault_stat_r & fault_mask_r);

    reset_zero_a: assert property (
        @(posedge i_clk) i_reset |=> sleep_gate_r == SLEEP_GATE_RST
    ) else $error("gate register not zero after reset");

    reserved_zero_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (sleep_gate_r & ~SLEEP_GATE_WMASK) == 32'h0000_0000
    ) else $error("reserved gate bit set");

    gate_write_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_write && !o_avs_waitrequest && i_avs_address == SLEEP_GATE_OFS
            && i_avs_byteenable == 4'hF)
        |=> sleep_gate_r == ($past(i_avs_writedata) & SLEEP_GATE_WMASK)
    ) else $error("gate register write not taken");

    // mac bit drives the mac enable in auto sleep
    mac_enable_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_sleep_mode && i_auto_clock_gate_select) ##1 1'b1
        |-> o_unit_clock_en[UNIT_MAC] == $past(sleep_gate_r[MAC_BIT])
            && o_unit_clock_en[UNIT_PHY] == $past(sleep_gate_r[PHY_BIT])
    ) else $error("ethernet enable does not follow gate bit");

    port_enable_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_sleep_mode && i_auto_clock_gate_select)
        |=> o_unit_clock_en[PORT_N-1:0] == $past(sleep_gate_r[PORT_N-1:0])
    ) else $error("port enable does not follow gate bit");

    // run gating held in sleep without auto select
    hold_run_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_sleep_mode && !i_auto_clock_gate_select)
        |=> o_unit_clock_en == units_of($past(i_run_clock_gate))
    ) else $error("run gating not kept during sleep");

    // run mode ignores the sleep register
    run_mode_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !i_sleep_mode |=> o_unit_clock_en == units_of($past(i_run_clock_gate))
    ) else $error("run mode gating wrong");

    // switch into auto sleep takes the sleep register
    auto_switch_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        $rose(i_sleep_mode) && i_auto_clock_gate_select
        |=> o_unit_clock_en == units_of($past(sleep_gate_r))
    ) else $error("auto gating not applied on sleep entry");

    gated_fault_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_unit_access & ~o_unit_clock_en) != '0
        |=> o_bus_fault == $past(i_unit_access & ~o_unit_clock_en)
    ) else $error("bus fault missing for gated unit");

    clocked_ok_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_unit_access & ~o_unit_clock_en) == '0 |=> o_bus_fault == '0
    ) else $error("bus fault on clocked unit");

    fault_sticky_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        fault_nxt != '0 |=> (fault_stat_r & $past(fault_nxt)) == $past(fault_nxt)
    ) else $error("fault not recorded in status");

    irq_level_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (fault_nxt & fault_mask_nxt) != '0 |=> o_irq
    ) else $error("interrupt low with unmasked status");

    wait_bound_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest
    ) else $error("bus answer too late");

    // read returns register at its offset
    gate_read_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_read && o_avs_waitrequest && i_avs_address == SLEEP_GATE_OFS)
        |=> o_avs_readdata == $past(sleep_gate_r)
    ) else $error("gate register read wrong");

    wait_once_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_read || i_avs_write) && !o_avs_waitrequest
        |=> o_avs_waitrequest == (i_avs_read || i_avs_write)
    ) else $error("wait state repeated after answer");

    // write one clears status, set wins
    stat_clear_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_write && !o_avs_waitrequest && hit_stat && i_avs_byteenable == 4'hF)
        |=> (fault_stat_r & $past(i_avs_writedata[UNIT_N-1:0] & ~fault_nxt)) == '0
    ) else $error("fault status not cleared");

    mask_write_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_write && !o_avs_waitrequest && hit_mask && i_avs_byteenable == 4'hF)
        |=> fault_mask_r == $past(i_avs_writedata[UNIT_N-1:0])
    ) else $error("fault mask write not taken");

    stat_read_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_read && o_avs_waitrequest && hit_stat)
        |=> o_avs_readdata == {{(32-UNIT_N){1'b0}}, $past(fault_stat_r)}
    ) else $error("fault status read wrong");

    unit_read_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_read && o_avs_waitrequest && hit_unit)
        |=> o_avs_readdata == {{(32-UNIT_N){1'b0}}, $past(o_unit_clock_en)}
    ) else $error("enable state read wrong");

    unmapped_read_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_read && o_avs_waitrequest && !(hit_gate || hit_stat || hit_mask || hit_unit))
        |=> o_avs_readdata == 32'h0000_0000
    ) else $error("unmapped read not zero");

    unmapped_write_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_write && !(hit_gate || hit_stat || hit_mask || hit_unit))
        |=> $stable(sleep_gate_r) && $stable(fault_mask_r)
    ) else $error("unmapped write changed a register");

    gate_hold_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !(i_avs_write && !o_avs_waitrequest && hit_gate) |=> $stable(sleep_gate_r)
    ) else $error("gate register changed without a write");

    // low lane write leaves the ethernet bits
    port_lane_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_write && !o_avs_waitrequest && hit_gate && i_avs_byteenable == 4'h1)
        |=> sleep_gate_r[PORT_N-1:0] == $past(i_avs_writedata[PORT_N-1:0])
            && sleep_gate_r[PHY_BIT] == $past(sleep_gate_r[PHY_BIT])
            && sleep_gate_r[MAC_BIT] == $past(sleep_gate_r[MAC_BIT])
    ) else $error("port lane write wrong");

    // top lane write leaves the port bits
    phy_lane_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_avs_write && !o_avs_waitrequest && hit_gate && i_avs_byteenable == 4'h8)
        |=> sleep_gate_r[PHY_BIT] == $past(i_avs_writedata[PHY_BIT])
            && sleep_gate_r[MAC_BIT] == $past(i_avs_writedata[MAC_BIT])
            && sleep_gate_r[PORT_N-1:0] == $past(sleep_gate_r[PORT_N-1:0])
    ) else $error("ethernet lane write wrong");

    // read data holds until the next read
    rdata_hold_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata)
    ) else $error("read data changed without a read");

    reset_quiet_a: assert property (
        @(posedge i_clk) i_reset |=> o_unit_clock_en == '0 && o_bus_fault == '0 && !o_irq
    ) else $error("outputs not quiet after reset");

    // dropping auto select restores run gating
    auto_drop_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        $fell(i_auto_clock_gate_select) && i_sleep_mode
        |=> o_unit_clock_en == units_of($past(i_run_clock_gate))
    ) else $error("run gating not restored when auto select drops");

endmodule // sleep_clock_gate

// file: test/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sleep_gate_pkg::*;
    typedef struct packed {logic [31:0] wdata; logic [3:0] be; logic [31:0] exp;} row_t;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [ADDR_W-1:0] i_avs_address = '0;
    logic i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [DATA_W-1:0] i_avs_writedata = '0, o_avs_readdata, i_run_clock_gate = '0, rd;
    logic o_avs_waitrequest, i_sleep_mode = 1'b0, i_auto_clock_gate_select = 1'b0, o_irq;
    logic [UNIT_N-1:0] i_unit_access = '0, o_unit_clock_en, o_bus_fault;
    int miscompares = 0;
    int check_count = 0;
    int cycle_count = 0;
    // partial lanes merge with what the previous row left
    row_t rows [8] = '{
        '{32'hFFFF_FFFF, 4'hF, 32'h5000_007F}, '{32'h0000_0000, 4'hF, 32'h0000_0000},
        '{32'hFFFF_FFFF, 4'h1, 32'h0000_007F}, '{32'hFFFF_FFFF, 4'h8, 32'h5000_007F},
        '{32'h4000_0000, 4'hF, 32'h4000_0000}, '{32'h1000_0000, 4'hF, 32'h1000_0000},
        '{32'hAAAA_AAAA, 4'hF, 32'h0000_002A}, '{32'h5555_5555, 4'hF, 32'h5000_0055}};

    sleep_clock_gate i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_sleep_mode(i_sleep_mode),
        .i_auto_clock_gate_select(i_auto_clock_gate_select), .i_run_clock_gate(i_run_clock_gate),
        .i_unit_access(i_unit_access), .o_unit_clock_en(o_unit_clock_en),
        .o_bus_fault(o_bus_fault), .o_irq(o_irq));

    always #12.5 i_clk = ~i_clk;

    function automatic logic [UNIT_N-1:0] units(input logic [31:0] v);
        return {v[30], v[28], v[6:0]};
    endfunction

    task automatic finish_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_units(input string name, input logic [8:0] exp, input logic [8:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // called right after a rising edge; request held until waitrequest is low at an edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        @(posedge i_clk);
        while (o_avs_waitrequest !== 1'b0)
        begin
            @(posedge i_clk);
        end
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        // idle edge so the next call never reassigns the strobes in this time step
        @(posedge i_clk);
    endtask

    task automatic read_check(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, '0, 4'hF, q);
        check_word(name, exp, q);
    endtask

    // gated enables are registered; two edges cover the register write landing too
    task automatic settle_units(input logic [8:0] exp);
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        check_units("clock_en", exp, o_unit_clock_en);
        @(posedge i_clk);
    endtask

    task automatic unit_hit(input logic [8:0] u, input logic [8:0] exp, input logic irq);
        i_unit_access <= u;
        @(posedge i_clk);
        i_unit_access <= '0;
        @(negedge i_clk);
        check_units("bus_fault", exp, o_bus_fault);
        @(posedge i_clk);
        check_units("irq", {8'h00, irq}, {8'h00, o_irq});
    endtask

    always @(posedge i_clk)
    begin
        cycle_count++;
        if (cycle_count == 4000)
        begin
            miscompares++;
            finish_test();
        end
    end

    initial
    begin
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        @(negedge i_clk);
        check_units("reset_en", 9'h000, o_unit_clock_en);
        @(posedge i_clk);
        read_check("gate_reset", SLEEP_GATE_OFS, SLEEP_GATE_RST);
        i_sleep_mode <= 1'b1;
        i_auto_clock_gate_select <= 1'b1;
        foreach (rows[i])
        begin
            bus(1'b1, SLEEP_GATE_OFS, rows[i].wdata, rows[i].be, rd);
            read_check("gate_reg", SLEEP_GATE_OFS, rows[i].exp);
            read_check("unit_state", UNIT_STATE_OFS, {23'h0, units(rows[i].exp)});
            settle_units(units(rows[i].exp));
        end
        i_run_clock_gate <= 32'h0000_0041;
        i_sleep_mode <= 1'b0;
        settle_units(9'h041);
        i_sleep_mode <= 1'b1;
        i_auto_clock_gate_select <= 1'b0;
        settle_units(9'h041);
        i_auto_clock_gate_select <= 1'b1;
        settle_units(9'h1D5);
        read_check("unmapped", 12'h11C, 32'h0000_0000);
        bus(1'b1, 12'h11C, 32'hFFFF_FFFF, 4'hF, rd);
        read_check("gate_kept", SLEEP_GATE_OFS, 32'h5000_0055);
        unit_hit(9'h002, 9'h002, 1'b0);
        read_check("fault_stat", FAULT_STAT_OFS, 32'h0000_0002);
        bus(1'b1, FAULT_MASK_OFS, 32'h0000_0002, 4'hF, rd);
        check_units("irq_mask", 9'h001, {8'h00, o_irq});
        unit_hit(9'h101, 9'h000, 1'b1);
        bus(1'b1, FAULT_STAT_OFS, 32'h0000_0002, 4'hF, rd);
        check_units("irq_clr", 9'h000, {8'h00, o_irq});
        read_check("fault_clr", FAULT_STAT_OFS, 32'h0000_0000);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        @(negedge i_clk);
        check_units("rereset_en", 9'h000, o_unit_clock_en);
        @(posedge i_clk);
        read_check("gate_rereset", SLEEP_GATE_OFS, 32'h0000_0000);
        finish_test();
    end
endmodule // tb
